// *** common/bc_consts.vh ***
// Constants shared by the marker block comparator design files
`ifndef BC_CONSTS_VH
`define BC_CONSTS_VH

// ****************************************************************
// Marker memory geometry
// ****************************************************************
`define BC_MEM_BYTES     32'h0000_0180
`define BC_MB_LAST       32'h0000_0180
`define BC_MW_LAST       32'h0000_00C0
`define BC_MD_LAST       32'h0000_0060
`define BC_ADDR_W        9
`define BC_SUM_W         10
`define BC_MEM_END       10'h180

// ****************************************************************
// Byte count limits
// ****************************************************************
`define BC_COUNT_MIN     32'h0000_0001
`define BC_COUNT_MAX     32'h0000_017F

// ****************************************************************
// Operand source kinds for the two range start inputs
// ****************************************************************
`define BC_SRC_CONST     3'h0
`define BC_SRC_MB        3'h1
`define BC_SRC_MW        3'h2
`define BC_SRC_MD        3'h3
`define BC_SRC_AIN       3'h4
`define BC_SRC_AOUT      3'h5
`define BC_SRC_BLKVAL    3'h6

`endif

// *** logic/bc_range_check.v ***
// Start address resolution and error evaluation for the block comparator
`timescale 1ns/1ns
`include "bc_consts.vh"

module bc_range_check (
  // Range start operands
  input  wire [2:0]  first_src_kind_i,
  input  wire [31:0] first_range_start_i,
  input  wire [2:0]  second_src_kind_i,
  input  wire [31:0] second_range_start_i,
  // Byte count operand value
  input  wire [31:0] byte_count_i,
  // Resolved ranges and error conditions
  output wire [8:0]  first_addr_o,
  output wire [8:0]  second_addr_o,
  output wire [8:0]  count_o,
  output wire        count_exceeds_o,
  output wire        overlap_o,
  output wire        offset_invalid_o
);

  // ****************************************************************
  // Start resolution: returns {valid, byte address}
  // ****************************************************************
  function [9:0] bc_resolve;
    input [2:0]  kind;
    input [31:0] val;
    reg   [31:0] idx;
    begin
      idx = val - 32'h0000_0001;
      case (kind)
        // Direct byte marker: marker location is the start
        `BC_SRC_MB: begin
          bc_resolve = {(val != 32'h0) && (val <= `BC_MB_LAST), idx[8:0]};
        end
        // Direct word marker: two bytes per word
        `BC_SRC_MW: begin
          bc_resolve = {(val != 32'h0) && (val <= `BC_MW_LAST), idx[7:0], 1'b0};
        end
        // Direct double-word marker: four bytes per double word
        `BC_SRC_MD: begin
          bc_resolve = {(val != 32'h0) && (val <= `BC_MD_LAST), idx[6:0], 2'b00};
        end
        // Constant, analog and block value act as offset from first byte
        `BC_SRC_CONST, `BC_SRC_AIN, `BC_SRC_AOUT, `BC_SRC_BLKVAL: begin
          bc_resolve = {!val[31] && (val < `BC_MEM_BYTES), val[8:0]};
        end
        // Unknown source kind is never valid
        default: begin
          bc_resolve = 10'h000;
        end
      endcase
    end
  endfunction

  wire [9:0]  res1_w     = bc_resolve(first_src_kind_i, first_range_start_i);
  wire [9:0]  res2_w     = bc_resolve(second_src_kind_i, second_range_start_i);
  wire        count_ok_w = !byte_count_i[31] && (byte_count_i >= `BC_COUNT_MIN) &&
                           (byte_count_i <= `BC_COUNT_MAX);
  wire        all_ok_w   = res1_w[9] && res2_w[9] && count_ok_w;
  wire [9:0]  end1_w     = {1'b0, res1_w[8:0]} + {1'b0, byte_count_i[8:0]};
  wire [9:0]  end2_w     = {1'b0, res2_w[8:0]} + {1'b0, byte_count_i[8:0]};

  assign first_addr_o     = res1_w[8:0];
  assign second_addr_o    = res2_w[8:0];
  assign count_o          = byte_count_i[8:0];
  // Either range running past the last double word
  assign count_exceeds_o  = all_ok_w && ((end1_w > `BC_MEM_END) ||
                                         (end2_w > `BC_MEM_END));
  // Second range starting inside the first span
  assign overlap_o        = all_ok_w && (res2_w[8:0] >= res1_w[8:0]) &&
                            ({1'b0, res2_w[8:0]} < end1_w);
  // Start or count outside the permitted marker range
  assign offset_invalid_o = !all_ok_w;

endmodule

// *** logic/bc_block_comparator.v ***
// Byte-wise comparator of two marker memory ranges with error flags
`timescale 1ns/1ns
`include "bc_consts.vh"

module bc_block_comparator (
  // Clock and reset
  input  wire        clock_i,
  input  wire        rst_n_i,
  // Scan control
  input  wire        scan_start_i,
  input  wire        compare_activate_coil_i,
  // Range operands
  input  wire [2:0]  first_src_kind_i,
  input  wire [31:0] first_range_start_i,
  input  wire [2:0]  second_src_kind_i,
  input  wire [31:0] second_range_start_i,
  input  wire [31:0] byte_count_i,
  // Marker memory read port
  output reg         mem_rd_en_o,
  output reg  [8:0]  mem_addr_o,
  input  wire [7:0]  mem_rd_data_i,
  // Result flags
  output reg         ranges_match_flag_o,
  output reg         count_exceeds_range_flag_o,
  output reg         ranges_overlap_flag_o,
  output reg         offset_invalid_flag_o,
  output reg         busy_o,
  output reg         compare_done_o
);

  // ****************************************************************
  // State encoding
  // ****************************************************************
  localparam [1:0] ST_IDLE   = 2'h0;  // Waiting for a scan start
  localparam [1:0] ST_READ_A = 2'h1;  // First range byte address on bus
  localparam [1:0] ST_READ_B = 2'h2;  // Second range byte address on bus
  localparam [1:0] ST_CHECK  = 2'h3;  // Both bytes available

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg  [1:0] state_q;       // Sequencer state
  reg  [8:0] ptr_a_q;       // Current first range address
  reg  [8:0] ptr_b_q;       // Current second range address
  reg  [8:0] remain_q;      // Byte pairs still to compare
  reg  [7:0] byte_a_q;      // Captured first range byte
  reg        all_eq_q;      // Running equality of pairs so far
  wire [8:0] first_addr_w;  // Resolved first start
  wire [8:0] second_addr_w; // Resolved second start
  wire [8:0] count_w;       // Byte count, low bits
  wire       exceeds_w;     // Count exceeds error
  wire       overlap_w;     // Overlap error
  wire       invalid_w;     // Invalid offset error
  wire       any_err_w;     // Any error present

  // Any error blocks a new comparison from being taken
  assign any_err_w = exceeds_w | overlap_w | invalid_w;

  // ****************************************************************
  // Address stepping
  // ****************************************************************
  // Next byte address of a range; both pointers and the bus use it
  function [8:0] bc_next_addr;
    input [8:0] addr;
    begin
      bc_next_addr = addr + 9'h001;
    end
  endfunction

  // ****************************************************************
  // Sequencer timing
  // ****************************************************************
  // The marker memory answers one cycle after an address is shown,
  // so each byte pair costs three cycles:
  //   READ_A : first range address shown, read enable high
  //   READ_B : second range address shown, first byte returns
  //   CHECK  : second byte returns and is folded into the result
  // A count of N therefore takes 3*N cycles from the start edge to
  // the done pulse. The start, pointers and count are latched when
  // the start is taken, so operands may change during a run; the
  // error flags keep following the live operands all the same.
  // Dropping the coil abandons the run without touching the match
  // flag, so a half-compared pair of ranges never reports a result.
  // The read enable drops during CHECK so that the memory is idle
  // while the last fetched byte is being compared.
  // Bytes are paired in ascending address order, first byte of
  // each range first, which gives double words their low byte first.
  // A count of one still runs one full pair; a count of zero is
  // refused by the range check as an invalid value.
  // While idle the memory port stays quiet with read enable low.
  // Reset clears the match flag and every error flag at once.

  // ****************************************************************
  // Address resolution and error evaluation
  // ****************************************************************
  bc_range_check u_range_check (
    .first_src_kind_i     (first_src_kind_i),
    .first_range_start_i  (first_range_start_i),
    .second_src_kind_i    (second_src_kind_i),
    .second_range_start_i (second_range_start_i),
    .byte_count_i         (byte_count_i),
    .first_addr_o         (first_addr_w),
    .second_addr_o        (second_addr_w),
    .count_o              (count_w),
    .count_exceeds_o      (exceeds_w),
    .overlap_o            (overlap_w),
    .offset_invalid_o     (invalid_w)
  );

  // ****************************************************************
  // Error flags, registered every cycle regardless of the coil
  // ****************************************************************
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_exceeds_range_flag_o <= 1'b0;
      ranges_overlap_flag_o      <= 1'b0;
      offset_invalid_flag_o      <= 1'b0;
    end else begin
      count_exceeds_range_flag_o <= exceeds_w;
      ranges_overlap_flag_o      <= overlap_w;
      offset_invalid_flag_o      <= invalid_w;
    end
  end

  // ****************************************************************
  // Comparison sequencer
  // ****************************************************************
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q             <= ST_IDLE;
      ptr_a_q             <= 9'h000;
      ptr_b_q             <= 9'h000;
      remain_q            <= 9'h000;
      byte_a_q            <= 8'h00;
      all_eq_q            <= 1'b1;
      mem_rd_en_o         <= 1'b0;
      mem_addr_o          <= 9'h000;
      ranges_match_flag_o <= 1'b0;
      busy_o              <= 1'b0;
      compare_done_o      <= 1'b0;
    end else begin
      compare_done_o <= 1'b0;
      if ((state_q != ST_IDLE) && !compare_activate_coil_i) begin
        // Coil dropped mid-scan: abandon, match flag keeps old value
        state_q     <= ST_IDLE;
        mem_rd_en_o <= 1'b0;
        busy_o      <= 1'b0;
      end else begin
        case (state_q)
          // Start only when enabled and error free
          ST_IDLE: begin
            if (scan_start_i && compare_activate_coil_i && !any_err_w) begin
              ptr_a_q     <= first_addr_w;
              ptr_b_q     <= second_addr_w;
              remain_q    <= count_w;
              all_eq_q    <= 1'b1;
              mem_addr_o  <= first_addr_w;
              mem_rd_en_o <= 1'b1;
              busy_o      <= 1'b1;
              state_q     <= ST_READ_A;
            end
          end
          // Present the second range address
          ST_READ_A: begin
            mem_addr_o <= ptr_b_q;
            state_q    <= ST_READ_B;
          end
          // First range byte returns now
          ST_READ_B: begin
            byte_a_q    <= mem_rd_data_i;
            mem_rd_en_o <= 1'b0;
            state_q     <= ST_CHECK;
          end
          // Second byte returns: fold into result, step ascending
          ST_CHECK: begin
            if (remain_q == 9'h001) begin
              ranges_match_flag_o <= all_eq_q && (byte_a_q == mem_rd_data_i);
              compare_done_o      <= 1'b1;
              busy_o              <= 1'b0;
              state_q             <= ST_IDLE;
            end else begin
              all_eq_q    <= all_eq_q && (byte_a_q == mem_rd_data_i);
              // More pairs left: advance both ranges by one byte
              ptr_a_q     <= bc_next_addr(ptr_a_q);
              ptr_b_q     <= bc_next_addr(ptr_b_q);
              remain_q    <= remain_q - 9'h001;
              // Show the next first range byte address at once
              mem_addr_o  <= bc_next_addr(ptr_a_q);
              mem_rd_en_o <= 1'b1;
              state_q     <= ST_READ_A;
            end
          end
          // Unused code: fall back to idle with the port quiet
          default: begin
            state_q     <= ST_IDLE;
            mem_rd_en_o <= 1'b0;
            busy_o      <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// *** verif/bc_mem_model.sv ***
// Marker memory model with one cycle registered read latency
`timescale 1ns/1ns
module bc_mem_model (
  // Clock
  input  wire       clock_i,
  // Read port from the comparator
  input  wire       rd_en_i,
  input  wire [8:0] addr_i,
  output reg  [7:0] rd_data_o,
  // Bench load port
  input  wire       wr_en_i,
  input  wire [8:0] wr_addr_i,
  input  wire [7:0] wr_data_i
);
  reg [7:0] mem_q [0:383];  // Marker bytes, index 0 is the first marker byte
  initial rd_data_o = 8'h00;
  // Idle cycles toggle the data so a stale byte is never mistaken for a fresh one
  always @(posedge clock_i) begin
    if (wr_en_i) mem_q[wr_addr_i] <= wr_data_i;
    if (rd_en_i) rd_data_o <= mem_q[addr_i];
    else rd_data_o <= ~rd_data_o;
  end
endmodule

// *** verif/bc_block_comparator_monitor.sv ***
// Port-level assertions for the block comparator
`timescale 1ns/1ns
module bc_block_comparator_monitor (
  input wire clock_i, input wire rst_n_i, input wire scan_start_i,
  input wire compare_activate_coil_i, input wire [2:0] first_src_kind_i,
  input wire [31:0] first_range_start_i, input wire [2:0] second_src_kind_i,
  input wire [31:0] second_range_start_i, input wire [31:0] byte_count_i,
  input wire mem_rd_en_o, input wire [8:0] mem_addr_o, input wire ranges_match_flag_o,
  input wire count_exceeds_range_flag_o, input wire ranges_overlap_flag_o,
  input wire offset_invalid_flag_o, input wire busy_o, input wire compare_done_o
);
  // Both starts plain offsets in range and count legal
  wire ok_c = first_src_kind_i == 3'h0 && second_src_kind_i == 3'h0 &&
    first_range_start_i < 32'h180 && second_range_start_i < 32'h180 &&
    byte_count_i != 32'h0 && byte_count_i < 32'h180;
  wire ex_c = first_range_start_i + byte_count_i > 32'h180 ||
    second_range_start_i + byte_count_i > 32'h180;
  wire ov_c = first_range_start_i <= second_range_start_i &&
    second_range_start_i < first_range_start_i + byte_count_i;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_start_cause: assert property ($rose(busy_o) |-> $past(scan_start_i) && $past(compare_activate_coil_i))
    else $error("comparison began without start and coil");
  a_no_err_start: assert property ($rose(busy_o) |-> !count_exceeds_range_flag_o && !ranges_overlap_flag_o && !offset_invalid_flag_o)
    else $error("comparison began with an error present");
  a_abort_coil: assert property (busy_o && !compare_activate_coil_i |=> !busy_o && !compare_done_o)
    else $error("coil low did not stop the comparison");
  a_read_order: assert property ($rose(busy_o) |-> mem_rd_en_o ##1 mem_rd_en_o ##1 !mem_rd_en_o)
    else $error("byte pair read sequence wrong");
  a_addr_step: assert property (mem_rd_en_o && busy_o && $past(busy_o) && $past(busy_o, 2) && $past(busy_o, 3) && $past(mem_rd_en_o, 3) |-> mem_addr_o == $past(mem_addr_o, 3) + 9'h1)
    else $error("address did not advance by one byte");
  a_done_pulse: assert property (compare_done_o |-> !busy_o ##1 !compare_done_o)
    else $error("done not a single pulse");
  a_match_hold: assert property (!compare_done_o |-> $stable(ranges_match_flag_o))
    else $error("match flag changed without done");
  a_exceeds_flag: assert property (ok_c |=> count_exceeds_range_flag_o == $past(ex_c))
    else $error("exceeds flag wrong");
  a_overlap_flag: assert property (ok_c && !ex_c |=> ranges_overlap_flag_o == $past(ov_c))
    else $error("overlap flag wrong");
  a_bad_kind: assert property (first_src_kind_i == 3'h7 |=> offset_invalid_flag_o)
    else $error("invalid kind not flagged");
endmodule
bind bc_block_comparator bc_block_comparator_monitor mon_u (.clock_i, .rst_n_i, .scan_start_i,
  .compare_activate_coil_i, .first_src_kind_i, .first_range_start_i, .second_src_kind_i,
  .second_range_start_i, .byte_count_i, .mem_rd_en_o, .mem_addr_o, .ranges_match_flag_o,
  .count_exceeds_range_flag_o, .ranges_overlap_flag_o, .offset_invalid_flag_o, .busy_o,
  .compare_done_o);

// *** verif/tb_top.sv ***
// Self-checking bench for the marker block comparator
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {logic [2:0] k1; logic [31:0] s1; logic [2:0] k2;
    logic [31:0] s2; logic [31:0] n; logic [3:0] x;} bc_row_t;  // x = match, e1, e2, e3
  reg clock_i = 0, rst_n_i = 0, scan = 0, coil = 0, we = 0;
  reg [2:0] k1 = 0, k2 = 0;
  reg [31:0] s1 = 0, s2 = 0, cnt = 0;
  reg [8:0] wa = 0;
  reg [7:0] wd = 0;
  wire en, m, e1, e2, e3, busy, done;
  wire [8:0] ad;
  wire [7:0] rd;
  int bad_count = 0, n_checks = 0, lat, i;
  logic em = 0;  // Expected match, held across refused runs
  // Word and double word offsets are supplied as (x-1)*2 and (x-1)*4
  bc_row_t rows [18] = '{'{1,10,1,74,5,8}, '{1,15,0,78,3,8}, '{1,15,0,78,4,0},
    '{2,5,4,72,6,8}, '{3,3,5,72,8,8}, '{6,9,3,19,2,0}, '{3,96,1,1,4,0},
    '{3,96,1,1,5,4}, '{2,60,2,64,12,2}, '{2,64,2,60,12,0}, '{0,100,0,0,383,4},
    '{1,129,0,192,64,8}, '{0,0,0,10,384,1}, '{0,0,0,10,0,1}, '{7,0,0,10,2,1},
    '{0,32'hFFFFFFFF,0,10,2,1}, '{1,0,1,10,2,1}, '{1,1,1,65,1,8}};
  bc_block_comparator dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .scan_start_i(scan),
    .compare_activate_coil_i(coil), .first_src_kind_i(k1), .first_range_start_i(s1),
    .second_src_kind_i(k2), .second_range_start_i(s2), .byte_count_i(cnt), .mem_rd_en_o(en),
    .mem_addr_o(ad), .mem_rd_data_i(rd), .ranges_match_flag_o(m),
    .count_exceeds_range_flag_o(e1), .ranges_overlap_flag_o(e2),
    .offset_invalid_flag_o(e3), .busy_o(busy), .compare_done_o(done));
  bc_mem_model mem_u (.clock_i(clock_i), .rd_en_i(en), .addr_i(ad), .rd_data_o(rd),
    .wr_en_i(we), .wr_addr_i(wa), .wr_data_i(wd));
  always #25 clock_i = ~clock_i;
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Apply one operand set at an edge and let the error flags settle
  task load(input bc_row_t r, input logic c);
    @(posedge clock_i);
    {k1, s1, k2, s2, cnt, coil} <= {r.k1, r.s1, r.k2, r.s2, r.n, c};
    repeat (2) @(posedge clock_i);
    #1;
  endtask
  // Pulse start and count edges until done, -1 when it never comes
  task automatic run(input int c, output int l);
    @(posedge clock_i);
    scan <= 1'b1;
    @(posedge clock_i);
    scan <= 1'b0;
    for (l = 1; l <= 3 * c + 12; l++) begin
      @(posedge clock_i);
      #1;
      if (done === 1'b1) return;
    end
    l = -1;
  endtask
  initial begin
    repeat (15) @(posedge clock_i);
    #1;
    chk("match", 0, m);
    chk("busy", 0, busy);
    @(posedge clock_i);
    rst_n_i <= 1'b1;
    // Byte a holds a mod 64, byte 81 spoiled
    for (i = 0; i < 386; i++) begin
      @(posedge clock_i);
      we <= i < 385;
      wa <= (i < 384) ? i[8:0] : 9'h051;
      wd <= (i < 384) ? {2'h0, i[5:0]} : 8'hFF;
    end
    for (i = 0; i < 18; i++) begin
      load(rows[i], 1'b1);
      chk("exceeds", rows[i].x[2], e1);
      chk("overlap", rows[i].x[1], e2);
      chk("invalid", rows[i].x[0], e3);
      if (rows[i].x[2:0] == 3'h0) em = rows[i].x[3];
      run(rows[i].n, lat);
      chk("latency", rows[i].x[2:0] == 3'h0 ? 3 * rows[i].n : -1, lat);
      chk("match", em, m);
      if (lat < 0 && rows[i].x[2:0] == 3'h0) close_out;
    end
    // Coil low: errors still shown, start ignored
    load(rows[7], 1'b0);
    chk("exceeds", 1, e1);
    load(rows[9], 1'b0);
    run(12, lat);
    chk("latency", -1, lat);
    // Coil dropped mid comparison aborts without touching the result
    load(rows[9], 1'b1);
    @(posedge clock_i);
    scan <= 1'b1;
    @(posedge clock_i);
    scan <= 1'b0;
    repeat (9) @(posedge clock_i);
    coil <= 1'b0;
    repeat (40) @(posedge clock_i);
    #1;
    chk("busy", 0, busy);
    chk("match", em, m);
    // Reset in mid comparison
    load(rows[11], 1'b1);
    run(1, lat);
    rst_n_i <= 1'b0;
    #1;
    chk("busy", 0, busy);
    chk("match", 0, m);
    close_out;
  end
endmodule
